// ### nfc_defines.vh
// Constants for the numeric format converter: opcodes, limits, timing.
// Assumes it is included by bare name from the converter design file.
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH

// ----------------------------------------------------------------------
// Conversion opcodes.
// ----------------------------------------------------------------------
`define NFC_OP_W 4
`define NFC_SHORT_TO_REAL 4'h0
`define NFC_LONG_TO_REAL 4'h1
`define NFC_REAL_TO_SHORT 4'h2
`define NFC_REAL_TO_LONG 4'h3
`define NFC_WORD_TO_DEC 4'h4
`define NFC_LONG_TO_DEC 4'h5
`define NFC_DEC_TO_WORD 4'h6
`define NFC_DEC_TO_LONG 4'h7
`define NFC_WORD_TO_REFL 4'h8
`define NFC_LONG_TO_REFL 4'h9

// ----------------------------------------------------------------------
// Range limits.
// ----------------------------------------------------------------------
`define NFC_WORD_DEC_MAX 32'h0000270F
`define NFC_LONG_DEC_MAX 32'h05F5E0FF
`define NFC_SHORT_MAX 32'h00007FFF
`define NFC_SHORT_MIN 32'hFFFF8000
`define NFC_LONG_MAX 32'h7FFFFFFF
`define NFC_LONG_MIN 32'h80000000
`define NFC_FLT_BIAS 8'h7F

// ----------------------------------------------------------------------
// Timing: cycles from the accepted start to the completion strobe.
// ----------------------------------------------------------------------
`define NFC_LATENCY 2

`endif

// ### nfc_converter.v
// Numeric format converter: integer/float, binary/BCD, binary/Gray.
// Assumes the sequencer presents operands on ports, synchronous to clock.
`timescale 1ns/100ps

// Operation
// - Convert and write destination only while enable is asserted; the write comes two cycles after the start even if enable drops.
// - Signed 16-bit integer converts to single-precision float pair.
// - Signed 32-bit integer from two units converts to float pair.
// - 32-bit operands occupy two consecutive 16-bit units.
// - Float to short drops the fraction, 10000.5 gives 10000.
// - Float to short sets zero for 0, borrow on dropped fraction.
// - Float to short saturates at 32767 or -32768 and sets carry.
// - Float to long drops the fraction into a destination pair.
// - Float to long sets zero, borrow and carry flags likewise.
// - Float to long saturates at 2147483647 and -2147483648.
// - Word to decimal gives four packed BCD digits.
// - Word to decimal above 9999 raises error, destination kept.
// - Long to decimal gives eight packed BCD digits in a pair.
// - Long to decimal above 99999999 raises error, destination kept.
// - Decimal to word converts packed BCD, 0x5555 gives 0x15B3.
// - Invalid BCD nibble in decimal to word raises error.
// - Decimal to long converts 32-bit packed BCD to binary.
// - Decimal to long checks every digit; bad digit raises error.
// - Word to reflected gives 16-bit Gray, 0xAAAA gives 0xFFFF.
// - Long to reflected gives 32-bit Gray in a register pair.
// - Zero and carry flags are dedicated status outputs.
module nfc_converter (
  input wire clock,
  input wire rst_b,
  input wire enable,
  input wire [3:0] op_code,
  input wire [15:0] src_lo,
  input wire [15:0] src_hi,
  output reg [15:0] dst_lo_r,
  output reg [15:0] dst_hi_r,
  output reg dst_we_r,
  output reg dst_pair_r,
  output reg zero_flag_r,
  output reg borrow_flag_r,
  output reg carry_overflow_flag_r,
  output reg operand_error_r,
  output reg done_r
);
`include "nfc_defines.vh"

  // ----------------------------------------------------------------------
  // States.
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_HOLD = 3'b100;
  // Last wait count; cut to the 2-bit counter on purpose where it is used.
  localparam [31:0] LAT_LAST = `NFC_LATENCY - 1;

  // Signed integer to IEEE single, truncating extra mantissa bits.
  function [31:0] int_to_real;
    input [31:0] v;
    reg sgn;
    reg [31:0] mag;
    reg [31:0] nrm;
    integer i;
    integer msb;
    begin
      sgn = v[31];
      mag = sgn ? (~v + 32'h00000001) : v;
      msb = 0;
      for (i = 0; i < 32; i = i + 1) begin
        if (mag[i]) begin
          msb = i;
        end
      end
      nrm = mag << (31 - msb);
      if (mag == 32'h00000000) begin
        int_to_real = 32'h00000000;
      end else begin
        int_to_real = {sgn, `NFC_FLT_BIAS + msb[7:0], nrm[30:8]};
      end
    end
  endfunction

  // Float to signed integer of 16 or 32 bits; returns {carry, borrow, val}.
  function [33:0] real_to_int;
    input [31:0] f;
    input is_long;
    reg [7:0] ex;
    reg [63:0] wide;
    reg [31:0] mag;
    reg [31:0] res;
    reg frac;
    reg ovf;
    integer sh;
    begin
      ex = f[30:23];
      wide = {40'h0000000000, 1'b1, f[22:0]};
      mag = 32'h00000000;
      frac = 1'b0;
      ovf = 1'b0;
      sh = ex - 150;
      if (ex == 8'h00) begin
        frac = (f[22:0] != 23'h000000);
      end else if (ex < `NFC_FLT_BIAS) begin
        frac = 1'b1;
      end else if (ex > 8'h9E) begin
        ovf = 1'b1;
      end else if (sh >= 0) begin
        wide = wide << sh;
        mag = wide[31:0];
      end else begin
        mag = wide[31:0] >> (-sh);
        frac = ((wide[31:0] << (32 + sh)) != 32'h00000000);
      end
      res = f[31] ? (~mag + 32'h00000001) : mag;
      if (is_long) begin
        if (ovf || (!f[31] && mag > `NFC_LONG_MAX) ||
            (f[31] && mag > `NFC_LONG_MIN)) begin
          ovf = 1'b1;
          res = f[31] ? `NFC_LONG_MIN : `NFC_LONG_MAX;
        end
      end else begin
        if (ovf || (!f[31] && mag > `NFC_SHORT_MAX) ||
            (f[31] && mag > 32'h00008000)) begin
          ovf = 1'b1;
          res = f[31] ? `NFC_SHORT_MIN : `NFC_SHORT_MAX;
        end
      end
      real_to_int = {ovf, frac & ~ovf, res};
    end
  endfunction

  // Binary to packed BCD by shift-and-add-three, eight digits.
  function [31:0] bin_to_dec;
    input [31:0] v;
    reg [63:0] s;
    integer i;
    integer d;
    begin
      s = {32'h00000000, v};
      for (i = 0; i < 32; i = i + 1) begin
        for (d = 0; d < 8; d = d + 1) begin
          if (s[32 + 4 * d +: 4] > 4'h4) begin
            s[32 + 4 * d +: 4] = s[32 + 4 * d +: 4] + 4'h3;
          end
        end
        s = s << 1;
      end
      bin_to_dec = s[63:32];
    end
  endfunction

  // Packed BCD to binary; bit 32 flags any nibble above nine.
  function [32:0] dec_to_bin;
    input [31:0] v;
    reg [31:0] acc;
    reg bad;
    integer d;
    begin
      acc = 32'h00000000;
      bad = 1'b0;
      for (d = 7; d >= 0; d = d - 1) begin
        if (v[4 * d +: 4] > 4'h9) begin
          bad = 1'b1;
        end
        acc = (acc << 3) + (acc << 1) + {28'h0000000, v[4 * d +: 4]};
      end
      dec_to_bin = {bad, acc};
    end
  endfunction

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] count_r;
  reg [31:0] res_r;
  reg [31:0] res_nxt;
  reg err_r;
  reg err_nxt;
  reg zf_nxt;
  reg bf_nxt;
  reg cf_nxt;
  reg [2:0] flags_r;
  reg pair_r;
  reg pair_nxt;
  reg [33:0] rt;
  reg [32:0] db;

  // 32-bit operands arrive as a pair, low unit first.
  wire [31:0] src_long = {src_hi, src_lo};
  wire [31:0] src_short = {{16{src_lo[15]}}, src_lo};
  wire [31:0] src_word = {16'h0000, src_lo};

  // ----------------------------------------------------------------------
  // Conversion datapath, evaluated on the operands of the start cycle.
  // ----------------------------------------------------------------------
  always @* begin
    res_nxt = 32'h00000000;
    err_nxt = 1'b0;
    bf_nxt = 1'b0;
    cf_nxt = 1'b0;
    pair_nxt = 1'b1;
    rt = real_to_int(src_long, 1'b0);
    db = dec_to_bin(src_long);
    case (op_code)
      `NFC_SHORT_TO_REAL: begin
        res_nxt = int_to_real(src_short);
      end
      `NFC_LONG_TO_REAL: begin
        res_nxt = int_to_real(src_long);
      end
      `NFC_REAL_TO_SHORT: begin
        res_nxt = rt[31:0];
        bf_nxt = rt[32];
        cf_nxt = rt[33];
        pair_nxt = 1'b0;
      end
      `NFC_REAL_TO_LONG: begin
        rt = real_to_int(src_long, 1'b1);
        res_nxt = rt[31:0];
        bf_nxt = rt[32];
        cf_nxt = rt[33];
      end
      `NFC_WORD_TO_DEC: begin
        err_nxt = (src_word > `NFC_WORD_DEC_MAX);
        res_nxt = bin_to_dec(src_word);
        pair_nxt = 1'b0;
      end
      `NFC_LONG_TO_DEC: begin
        err_nxt = (src_long > `NFC_LONG_DEC_MAX);
        res_nxt = bin_to_dec(src_long);
      end
      `NFC_DEC_TO_WORD: begin
        db = dec_to_bin(src_word);
        err_nxt = db[32];
        res_nxt = db[31:0];
        pair_nxt = 1'b0;
      end
      `NFC_DEC_TO_LONG: begin
        err_nxt = db[32];
        res_nxt = db[31:0];
      end
      `NFC_WORD_TO_REFL: begin
        res_nxt = src_word ^ (src_word >> 1);
        pair_nxt = 1'b0;
      end
      `NFC_LONG_TO_REFL: begin
        res_nxt = src_long ^ (src_long >> 1);
      end
      default: begin
        err_nxt = 1'b1;
        pair_nxt = 1'b0;
      end
    endcase
    zf_nxt = pair_nxt ? (res_nxt == 32'h00000000) :
      (res_nxt[15:0] == 16'h0000);
  end

  // Sequencer: an enabled start runs once; enable must drop before the
  // next execution, which keeps a held enable from spraying results.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (enable) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (count_r == 2'd0) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!enable) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers; outputs all come from flip-flops.
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      count_r <= 2'd0;
      res_r <= 32'h00000000;
      err_r <= 1'b0;
      flags_r <= 3'b000;
      pair_r <= 1'b0;
      dst_lo_r <= 16'h0000;
      dst_hi_r <= 16'h0000;
      dst_we_r <= 1'b0;
      dst_pair_r <= 1'b0;
      zero_flag_r <= 1'b0;
      borrow_flag_r <= 1'b0;
      carry_overflow_flag_r <= 1'b0;
      operand_error_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dst_we_r <= 1'b0;
      operand_error_r <= 1'b0;
      done_r <= 1'b0;
      if (state_r == ST_IDLE && enable) begin
        count_r <= LAT_LAST[1:0];
        res_r <= res_nxt;
        err_r <= err_nxt;
        flags_r <= {zf_nxt, bf_nxt, cf_nxt};
        pair_r <= pair_nxt;
      end else if (state_r == ST_WAIT) begin
        count_r <= count_r - 2'd1;
        if (count_r == 2'd0) begin
          done_r <= 1'b1;
          operand_error_r <= err_r;
          if (!err_r) begin
            // Destination and flags only move on a good result.
            dst_lo_r <= res_r[15:0];
            dst_hi_r <= pair_r ? res_r[31:16] : 16'h0000;
            dst_we_r <= 1'b1;
            dst_pair_r <= pair_r;
            zero_flag_r <= flags_r[2];
            borrow_flag_r <= flags_r[1];
            carry_overflow_flag_r <= flags_r[0];
          end
        end
      end
    end
  end
endmodule // nfc_converter

// ### nfc_converter_monitor.sv
// Checker for the converter: strobe timing, held results, Gray results.
// Assumes it is bound to the converter top and sees only its ports.
`timescale 1ns/100ps
`include "nfc_defines.vh"
module nfc_conv_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic [3:0] op_code,
  input wire logic [15:0] src_lo,
  input wire logic [15:0] src_hi,
  input wire logic [15:0] dst_lo_r,
  input wire logic [15:0] dst_hi_r,
  input wire logic dst_we_r,
  input wire logic dst_pair_r,
  input wire logic zero_flag_r,
  input wire logic borrow_flag_r,
  input wire logic carry_overflow_flag_r,
  input wire logic operand_error_r,
  input wire logic done_r
);
  // ----------------------------------------------------------------------
  // Properties, all in the one clock domain.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // The strobe is seen three sampling edges after the taking edge.
  a_done_latency:
    assert property (done_r |-> $past(enable, 3)) else $error("early done");
  a_done_single:
    assert property (done_r |=> !done_r) else $error("done too long");
  a_write_ok:
    assert property (dst_we_r |-> done_r && !operand_error_r)
      else $error("write without done");
  a_error_only:
    assert property (operand_error_r |-> done_r && !dst_we_r)
      else $error("error with write");
  a_dst_hold:
    assert property (!dst_we_r |-> $stable({dst_hi_r, dst_lo_r,
      zero_flag_r, borrow_flag_r, carry_overflow_flag_r}))
      else $error("result moved without write");
  a_zero_flag:
    assert property (dst_we_r |-> zero_flag_r == (dst_pair_r ?
      {dst_hi_r, dst_lo_r} == 32'h0 : dst_lo_r == 16'h0))
      else $error("zero flag wrong");
  a_gray_word:
    assert property (dst_we_r && $past(op_code, 3) == `NFC_WORD_TO_REFL
      |-> {dst_hi_r, dst_lo_r} == {16'h0, $past(src_lo, 3)
      ^ ($past(src_lo, 3) >> 1)}) else $error("word gray wrong");
  a_gray_long:
    assert property (dst_we_r && $past(op_code, 3) == `NFC_LONG_TO_REFL
      |-> {dst_hi_r, dst_lo_r} == ($past({src_hi, src_lo}, 3)
      ^ ($past({src_hi, src_lo}, 3) >> 1))) else $error("long gray wrong");
  a_word_range:
    assert property (done_r && $past(op_code, 3) == `NFC_WORD_TO_DEC
      && $past(src_lo, 3) > 16'h270F |-> operand_error_r)
      else $error("range not refused");

  c_write: cover property (dst_we_r);
  c_error: cover property (operand_error_r);
  c_carry: cover property (dst_we_r && carry_overflow_flag_r);
endmodule // nfc_conv_monitor

// ### nfc_converter_bench.sv
// Self-checking bench for the converter: one run per call, then compare.
// Assumes the converter, its defines header and the monitor are compiled.
`timescale 1ns/100ps
`include "nfc_defines.vh"
module nfc_converter_bench;
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  reg enable = 1'b0;
  reg [3:0] op_code = 4'h0;
  reg [15:0] src_lo = 16'h0;
  reg [15:0] src_hi = 16'h0;
  wire [15:0] dst_lo_r;
  wire [15:0] dst_hi_r;
  wire dst_we_r, dst_pair_r, zero_flag_r, borrow_flag_r;
  wire carry_overflow_flag_r, operand_error_r, done_r;
  integer err_total = 0;
  integer tests_run = 0;
  integer n;
  reg [31:0] last_d = 32'h0;
  reg [2:0] last_f = 3'h0;
  reg last_p = 1'b0;

  always #50 clock = ~clock;

  nfc_converter i_nfc_converter (.clock(clock), .rst_b(rst_b),
    .enable(enable), .op_code(op_code), .src_lo(src_lo), .src_hi(src_hi),
    .dst_lo_r(dst_lo_r), .dst_hi_r(dst_hi_r), .dst_we_r(dst_we_r),
    .dst_pair_r(dst_pair_r), .zero_flag_r(zero_flag_r),
    .borrow_flag_r(borrow_flag_r),
    .carry_overflow_flag_r(carry_overflow_flag_r),
    .operand_error_r(operand_error_r), .done_r(done_r));

  // ----------------------------------------------------------------------
  // Verdict, compare and run tasks.
  // ----------------------------------------------------------------------
  task end_sim;
    begin
      if (err_total == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task check(input [8*8-1:0] name, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // A refused run must leave result and flags as the last good run left
  // them, so the expectation falls back to what was last predicted.
  task conv(input [3:0] op, input [31:0] src, input bad,
            input [31:0] exp_d, input [2:0] exp_f);
    integer k;
    begin
      @(posedge clock);
      #1;
      enable = 1'b1;
      op_code = op;
      {src_hi, src_lo} = src;
      k = 0;
      while (done_r !== 1'b1 && k < 8) begin
        @(posedge clock);
        #1;
        k = k + 1;
      end
      if (k == 8) begin
        err_total = err_total + 1;
        end_sim;
      end
      if (!bad) begin
        last_d = exp_d;
        last_f = exp_f;
        // Opcodes 0, 1, 3, 5, 7 and 9 write a register pair.
        last_p = op[0] | (op == 4'h0);
      end
      // The count includes the taking edge itself.
      check("latency", `NFC_LATENCY + 1, k);
      check("strobes", {30'h0, bad, ~bad},
        {30'h0, operand_error_r, dst_we_r});
      check("result", last_d, {dst_hi_r, dst_lo_r});
      check("flags", {29'h0, last_f}, {29'h0, zero_flag_r,
        borrow_flag_r, carry_overflow_flag_r});
      check("pair", {31'h0, last_p}, {31'h0, dst_pair_r});
      enable = 1'b0;
      @(posedge clock);
      #1;
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    #1;
    rst_b = 1'b1;
    conv(4'h0, 32'h00002715, 1'b0, 32'h461C5400, 3'h0);
    conv(4'h0, 32'h0000FFFF, 1'b0, 32'hBF800000, 3'h0);
    conv(4'h1, 32'h000186A0, 1'b0, 32'h47C35000, 3'h0);
    conv(4'h2, 32'h461C4200, 1'b0, 32'h00002710, 3'h2);
    conv(4'h2, 32'h3F000000, 1'b0, 32'h00000000, 3'h6);
    conv(4'h2, 32'h471C4000, 1'b0, 32'h00007FFF, 3'h1);
    conv(4'h2, 32'hC71C4000, 1'b0, 32'h00008000, 3'h1);
    conv(4'h3, 32'h47C35040, 1'b0, 32'h000186A0, 3'h2);
    conv(4'h3, 32'h4F800000, 1'b0, 32'h7FFFFFFF, 3'h1);
    conv(4'h3, 32'hCF800000, 1'b0, 32'h80000000, 3'h1);
    conv(4'h4, 32'h00000D05, 1'b0, 32'h00003333, 3'h0);
    conv(4'h4, 32'h0000270F, 1'b0, 32'h00009999, 3'h0);
    conv(4'h4, 32'h00002710, 1'b1, 32'h0, 3'h0);
    conv(4'h5, 32'h03F940AA, 1'b0, 32'h66666666, 3'h0);
    conv(4'h5, 32'h05F5E100, 1'b1, 32'h0, 3'h0);
    conv(4'h6, 32'h00005555, 1'b0, 32'h000015B3, 3'h0);
    conv(4'h6, 32'h000012A4, 1'b1, 32'h0, 3'h0);
    conv(4'h7, 32'h99999999, 1'b0, 32'h05F5E0FF, 3'h0);
    conv(4'h7, 32'hA0000001, 1'b1, 32'h0, 3'h0);
    conv(4'h8, 32'h0000AAAA, 1'b0, 32'h0000FFFF, 3'h0);
    conv(4'h9, 32'h88888888, 1'b0, 32'hCCCCCCCC, 3'h0);
    conv(4'hF, 32'h00000001, 1'b1, 32'h0, 3'h0);
    // A held enable must give exactly one run, never a repeat.
    @(posedge clock);
    #1;
    enable = 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge clock);
      #1;
      n = n + done_r;
    end
    check("one run", 32'h1, n);
    end_sim;
  end
endmodule // nfc_converter_bench

bind nfc_converter nfc_conv_monitor i_nfc_conv_monitor (.clock(clock),
  .rst_b(rst_b), .enable(enable), .op_code(op_code), .src_lo(src_lo),
  .src_hi(src_hi), .dst_lo_r(dst_lo_r), .dst_hi_r(dst_hi_r),
  .dst_we_r(dst_we_r), .dst_pair_r(dst_pair_r),
  .zero_flag_r(zero_flag_r), .borrow_flag_r(borrow_flag_r),
  .carry_overflow_flag_r(carry_overflow_flag_r),
  .operand_error_r(operand_error_r), .done_r(done_r));
